// ---- hw/nvmcac_defs.vh ----
// nvmcac_defs.vh: offsets, fields and codes of the flash access block
// assumes inclusion by nvmcac_top.v only
// Operation
// - ports 0/1 into emulation area get error
// - command in emulation area: done and address error
// - emulation area sits at top of main array
// - boot area always write/erase protected
// - bank order bit picks bank at base
// - fixed priority: port 0, 1, then 2
// - granted data phase finishes before others
// - bursts keep the port until they end
// - per-port bit (ports 0 and 1 only) forces re-arbitration inside bursts
// - main array has 32 lockable regions
// - region size follows flash capacity
// - lock/unlock commands hit region of address
// - lock defaults loaded from configuration at startup
// - reads/auto writes over AHB, rest by command
// - command plus key starts; ready low while busy
// - command while busy ignored, programming error
// - invalid command: programming error and done
// - address register loaded by APB and AHB writes
// - locked address write discarded, address error
// - address held until buffer write or auto command
// - address error blocks address commands
// - read data after configured wait states
// - read of busy bank stalls, other proceeds
// - unsupported command for space: programming error
`ifndef NVMCAC_DEFS_VH
`define NVMCAC_DEFS_VH
`define NV_A_CTRLA   8'h00
`define NV_A_CTRLB   8'h04
`define NV_A_STATUS  8'h08
`define NV_A_INTFLAG 8'h0C
`define NV_A_ADDR    8'h10
`define NV_A_REGION_UNLOCK_STATUS 8'h14
`define NV_A_SEESTAT 8'h18
`define NV_A_PARAM   8'h1C
`define NV_F_RWS     3:0
`define NV_F_WM      5:4
`define NV_F_FRB     9:8
`define NV_F_CMD     6:0
`define NV_F_KEY     15:8
`define NV_F_BOOT    11:8
`define NV_F_BLK     3:0
`define NV_B_READY   0
`define NV_B_ORDER   1
`define NV_B_ALOCK   2
`define NV_B_DONE    0
`define NV_B_ADDRE   1
`define NV_B_PROGE   2
`define NV_KEY       8'hA5
`define NV_CMD_EP    7'h00
`define NV_CMD_EB    7'h01
`define NV_CMD_WP    7'h03
`define NV_CMD_WQW   7'h04
`define NV_CMD_LR    7'h11
`define NV_CMD_UR    7'h12
`define NV_WM_MAN    2'h0
`define NV_WM_ADW    2'h1
`define NV_WM_AQW    2'h2
`define NV_WM_APW    2'h3
`define NV_EE_SH     14
`define NV_BOOT_SH   13
`define NV_BOOT_TOP  4'hF
`define NV_PAGE_SH   9
`define NV_USER_BASE 24'h804000
`define NV_RS_1024   15
`define NV_RS_512    14
`define NV_RS_256    13
`define NV_RWS_RST   4'h0
`endif

// ---- hw/nvmcac_top.v ----
// nvmcac_top.v: AHB port arbiter, address map guard, region locks,
// command interface and address register of the flash controller
// assumes one clock for AHB and APB; flash array and page buffer are
// external logic on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "nvmcac_defs.vh"
module nvmcac_top #(
	parameter FLASH_KB = 1024,
	parameter AW       = 24
) (
	input  wire          pclk,                  // clock
	input  wire          presetn,               // async reset
	input  wire [7:0]    paddr,                 // apb address
	input  wire          psel,                  // apb select
	input  wire          penable,               // apb enable
	input  wire          pwrite,                // apb direction
	input  wire [31:0]   pwdata,                // apb write data
	output reg           pready,                // apb ready
	output reg  [31:0]   prdata,                // apb read data
	output reg           pslverr,               // apb error
	input  wire [5:0]    ahb_htrans,            // htrans, 2 bits/port
	input  wire [3*AW-1:0] ahb_haddr,           // haddr per port
	input  wire [2:0]    ahb_hwrite,            // hwrite per port
	input  wire [8:0]    ahb_hburst,            // hburst, 3 bits/port
	input  wire [95:0]   ahb_hwdata,            // hwdata per port
	output reg  [2:0]    ahb_hreadyout,         // hreadyout per port
	output reg  [2:0]    ahb_hresp,             // error response
	output reg  [31:0]   ahb_hrdata,            // shared read data
	output reg           flash_rd_req,          // array read pulse
	output reg           flash_rd_bank,         // physical bank
	output reg  [AW-1:0] flash_rd_addr,         // read address
	input  wire [31:0]   flash_rdata,           // array read data
	output reg           pb_wr,                 // page buffer write
	output reg  [AW-1:0] pb_addr,               // buffer address
	output reg  [31:0]   pb_wdata,              // buffer data
	output reg           flash_cmd_req,         // operation start
	output reg  [6:0]    flash_cmd_code,        // command_code
	output reg  [AW-1:0] flash_cmd_addr,        // operation address
	output reg           flash_cmd_bank,        // physical bank
	input  wire          flash_cmd_done,        // operation end pulse
	input  wire [31:0]   cfg_region_unlock,     // lock defaults
	input  wire [3:0]    cfg_boot_protect_size, // boot_protect_size
	input  wire [3:0]    cfg_emulation_blocks,  // emulation_block_count
	input  wire          cfg_bank_order_select  // bank_order_select
);
	localparam RS = (FLASH_KB == 1024) ? `NV_RS_1024 :
		(FLASH_KB == 512) ? `NV_RS_512 : `NV_RS_256;
	localparam BB = RS + 4;
	localparam [31:0] MAIN_W = FLASH_KB * 1024;
	localparam [AW-1:0] MAIN_B = MAIN_W[AW-1:0];
	localparam [31:0] PAGE_W = FLASH_KB * 2;
	localparam [15:0] PAGES = PAGE_W[15:0];
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_WAIT = 2'h1;
	localparam [1:0] ST_ERR  = 2'h2;

	reg  [3:0]    rws_ff;
	reg  [1:0]    write_mode_select_ff;
	reg  [1:0]    frb_ff;
	reg  [AW-1:0] addr_ff;
	reg  [31:0]   unlock_ff;
	reg           done_ff;
	reg           addre_ff;
	reg           proge_ff;
	reg           ready_ff;
	reg           cfg_ld_ff;
	reg           order_ff;
	reg  [3:0]    boot_ff;
	reg  [3:0]    eeblk_ff;
	reg           alock_ff;
	reg           op_bank_ff;
	reg           op_main_ff;
	reg  [1:0]    state_ff;
	reg  [1:0]    gnt_ff;
	reg  [3:0]    cnt_ff;
	reg           lock_ff;
	reg  [1:0]    lport_ff;

	wire [2:0]      cap;
	wire [2:0]      pend;
	wire [2:0]      q_wr;
	wire [2:0]      q_bst;
	wire [3*AW-1:0] q_addr;
	reg  [2:0]      fin;

	// emulation area at top of main array
	wire [AW-1:0] ee_start = MAIN_B - ({{(AW-4){1'b0}}, eeblk_ff} << `NV_EE_SH);
	wire [AW-1:0] boot_end = {{(AW-4){1'b0}}, `NV_BOOT_TOP - boot_ff} << `NV_BOOT_SH;

	function in_ee;
		input [AW-1:0] a;
		in_ee = (a >= ee_start) && (a < MAIN_B);
	endfunction

	function pbank;
		input [AW-1:0] a;
		pbank = a[BB] ^ ~order_ff;
	endfunction

	genvar p;
	generate
		for (p = 0; p < 3; p = p + 1) begin : g_port
			reg          v_ff;
			reg          w_ff;
			reg          b_ff;
			reg [AW-1:0] a_ff;
			assign cap[p] = ahb_hreadyout[p] & ahb_htrans[2*p+1] & ~v_ff;
			assign pend[p] = v_ff;
			assign q_wr[p] = w_ff;
			assign q_bst[p] = b_ff;
			assign q_addr[p*AW +: AW] = a_ff;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					v_ff <= 1'b0;
					w_ff <= 1'b0;
					b_ff <= 1'b0;
					a_ff <= {AW{1'b0}};
				end else begin
					if (cap[p]) begin
						v_ff <= 1'b1;
						w_ff <= ahb_hwrite[p];
						b_ff <= |ahb_hburst[3*p +: 3];
						a_ff <= ahb_haddr[p*AW +: AW];
					end else if (fin[p]) begin
						v_ff <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// arbitration
	reg [1:0] sel;
	reg       sel_v;
	always @* begin
		sel = 2'h0;
		sel_v = 1'b0;
		if (lock_ff) begin
			sel = lport_ff;
			sel_v = pend[lport_ff];
		end else if (pend[0]) begin
			sel = 2'h0;
			sel_v = 1'b1;
		end else if (pend[1]) begin
			sel = 2'h1;
			sel_v = 1'b1;
		end else if (pend[2]) begin
			sel = 2'h2;
			sel_v = 1'b1;
		end
	end

	wire [AW-1:0] sa = q_addr[sel*AW +: AW];
	wire          sw = q_wr[sel];
	wire          s_main = sa < MAIN_B;
	wire          s_user = sa[AW-1:`NV_PAGE_SH] == `NV_USER_BASE >> `NV_PAGE_SH;
	wire          ee_err = (sel != 2'h2) && in_ee(sa);
	// writes wait for the command interface; reads only for their own bank
	wire          blk = sw ? ~ready_ff :
		(~ready_ff & op_main_ff & s_main & (pbank(sa) == op_bank_ff));
	wire          go = (state_ff == ST_IDLE) & sel_v & (ee_err | ~blk);
	wire          wgo = go & sw & ~ee_err;
	wire          rgo = go & ~sw & ~ee_err;
	wire [6:0]    widx = sa[8:2];
	wire          apw_ok = (write_mode_select_ff == `NV_WM_APW) & ~s_user;
	wire          last = (write_mode_select_ff == `NV_WM_ADW) ? widx[0] :
		(write_mode_select_ff == `NV_WM_AQW) | (write_mode_select_ff == `NV_WM_APW & s_user) ? &widx[1:0] :
		apw_ok ? &widx : 1'b0;
	wire          auto_go = wgo & last;

	// apb decode; writes take effect on the edge that shows pready
	wire apb_wr = psel & penable & pready & pwrite;
	wire cmd_apb = apb_wr & (paddr == `NV_A_CTRLB) & (pwdata[`NV_F_KEY] == `NV_KEY);
	wire flg_wr = apb_wr & (paddr == `NV_A_INTFLAG);
	wire adr_wr = apb_wr & (paddr == `NV_A_ADDR);
	// the address is in use while buffering or while a command runs
	wire adr_bad = adr_wr & (alock_ff | ~ready_ff | wgo);

	reg          s_prog;
	reg          s_done;
	reg          s_adre;
	reg          s_start;
	reg          lk_wr;
	reg [6:0]    c_code;
	reg [AW-1:0] c_addr;
	reg          c_main;
	reg          c_user;
	reg          c_ok;
	reg          c_sup;
	always @* begin
		c_code = auto_go ? (apw_ok ? `NV_CMD_WP : `NV_CMD_WQW) : pwdata[`NV_F_CMD];
		c_addr = auto_go ? sa : addr_ff;
		c_main = c_addr < MAIN_B;
		c_user = c_addr[AW-1:`NV_PAGE_SH] == `NV_USER_BASE >> `NV_PAGE_SH;
		c_ok = (c_code == `NV_CMD_EP) | (c_code == `NV_CMD_EB) | (c_code == `NV_CMD_WP) |
			(c_code == `NV_CMD_WQW) | (c_code == `NV_CMD_LR) | (c_code == `NV_CMD_UR);
		c_sup = c_main ? (c_code != `NV_CMD_EP) :
			c_user & ((c_code == `NV_CMD_WQW) | (c_code == `NV_CMD_EP));
		s_prog = 1'b0;
		s_done = 1'b0;
		s_adre = adr_bad;
		s_start = 1'b0;
		lk_wr = 1'b0;
		if (cmd_apb & (~ready_ff | auto_go)) begin
			s_prog = 1'b1;
		end else if (cmd_apb | auto_go) begin
			if (!c_ok) begin
				s_prog = 1'b1;
				s_done = 1'b1;
			end else if (addre_ff) begin
				s_prog = 1'b1;
			end else if (in_ee(c_addr)) begin
				s_done = 1'b1;
				s_adre = 1'b1;
			end else if ((c_code == `NV_CMD_LR) | (c_code == `NV_CMD_UR)) begin
				lk_wr = c_main;
				s_done = 1'b1;
			end else if (c_main & (c_addr < boot_end)) begin
				s_prog = 1'b1;
			end else if (c_main & ~unlock_ff[c_addr[RS +: 5]]) begin
				s_prog = 1'b1;
			end else if (!c_sup) begin
				s_prog = 1'b1;
			end else begin
				s_start = 1'b1;
			end
		end
	end

	// command, flags and configuration
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rws_ff <= `NV_RWS_RST;
			write_mode_select_ff <= `NV_WM_MAN;
			frb_ff <= 2'h0;
			addr_ff <= {AW{1'b0}};
			unlock_ff <= 32'h00000000;
			done_ff <= 1'b0;
			addre_ff <= 1'b0;
			proge_ff <= 1'b0;
			ready_ff <= 1'b1;
			cfg_ld_ff <= 1'b0;
			order_ff <= 1'b1;
			boot_ff <= 4'h0;
			eeblk_ff <= 4'h0;
			alock_ff <= 1'b0;
			op_bank_ff <= 1'b0;
			op_main_ff <= 1'b0;
			flash_cmd_req <= 1'b0;
			flash_cmd_code <= 7'h00;
			flash_cmd_addr <= {AW{1'b0}};
			flash_cmd_bank <= 1'b0;
		end else begin
			cfg_ld_ff <= 1'b1;
			if (!cfg_ld_ff) begin
				unlock_ff <= cfg_region_unlock;
				order_ff <= cfg_bank_order_select;
				boot_ff <= cfg_boot_protect_size;
				eeblk_ff <= cfg_emulation_blocks;
			end else if (lk_wr) begin
				unlock_ff[c_addr[RS +: 5]] <= (c_code == `NV_CMD_UR);
			end
			if (apb_wr & (paddr == `NV_A_CTRLA)) begin
				rws_ff <= pwdata[`NV_F_RWS];
				write_mode_select_ff <= pwdata[`NV_F_WM];
				frb_ff <= pwdata[`NV_F_FRB];
			end
			if (wgo)
				addr_ff <= sa;
			else if (adr_wr & ~adr_bad)
				addr_ff <= pwdata[AW-1:0];
			// set wins over a same-cycle clear
			done_ff <= (done_ff & ~(flg_wr & pwdata[`NV_B_DONE])) | s_done | flash_cmd_done;
			addre_ff <= (addre_ff & ~(flg_wr & pwdata[`NV_B_ADDRE])) | s_adre;
			proge_ff <= (proge_ff & ~(flg_wr & pwdata[`NV_B_PROGE])) | s_prog;
			if (wgo)
				alock_ff <= ~auto_go & (write_mode_select_ff != `NV_WM_MAN);
			else if (write_mode_select_ff == `NV_WM_MAN)
				alock_ff <= 1'b0;
			flash_cmd_req <= s_start;
			if (s_start) begin
				ready_ff <= 1'b0;
				op_bank_ff <= pbank(c_addr);
				op_main_ff <= c_main;
				flash_cmd_code <= c_code;
				flash_cmd_addr <= c_addr;
				flash_cmd_bank <= pbank(c_addr);
			end else if (flash_cmd_done) begin
				ready_ff <= 1'b1;
			end
		end
	end

	// ahb data phase
	always @* begin
		fin = 3'h0;
		if (wgo)
			fin[sel] = 1'b1;
		else if (state_ff == ST_ERR)
			fin[gnt_ff] = 1'b1;
		else if ((state_ff == ST_WAIT) && (cnt_ff == 4'h0))
			fin[gnt_ff] = 1'b1;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_IDLE;
			gnt_ff <= 2'h0;
			cnt_ff <= 4'h0;
			lock_ff <= 1'b0;
			lport_ff <= 2'h0;
			ahb_hreadyout <= 3'h7;
			ahb_hresp <= 3'h0;
			ahb_hrdata <= 32'h00000000;
			flash_rd_req <= 1'b0;
			flash_rd_bank <= 1'b0;
			flash_rd_addr <= {AW{1'b0}};
			pb_wr <= 1'b0;
			pb_addr <= {AW{1'b0}};
			pb_wdata <= 32'h00000000;
		end else begin
			ahb_hreadyout <= (ahb_hreadyout & ~cap) | fin;
			flash_rd_req <= rgo;
			pb_wr <= wgo;
			if (go) begin
				gnt_ff <= sel;
				lport_ff <= sel;
				// a port with its force bit set is re-arbitrated mid-burst
				lock_ff <= q_bst[sel] & ~((sel != 2'h2) & frb_ff[sel[0]]);
			end else if (lock_ff & ahb_hreadyout[lport_ff] & ~ahb_htrans[2*lport_ff]) begin
				lock_ff <= 1'b0;
			end
			// an error stands for its two cycles only, even if a transfer follows at once
			if (state_ff != ST_ERR)
				ahb_hresp <= 3'h0;
			if (go & ee_err) begin
				ahb_hresp[sel] <= 1'b1;
				state_ff <= ST_ERR;
			end else if (rgo) begin
				cnt_ff <= rws_ff;
				flash_rd_addr <= sa;
				flash_rd_bank <= pbank(sa);
				state_ff <= ST_WAIT;
			end else if (wgo) begin
				pb_addr <= sa;
				pb_wdata <= ahb_hwdata[32*sel +: 32];
			end else if (state_ff == ST_WAIT) begin
				if (cnt_ff == 4'h0) begin
					ahb_hrdata <= flash_rdata;
					state_ff <= ST_IDLE;
				end else begin
					cnt_ff <= cnt_ff - 4'h1;
				end
			end else if (state_ff == ST_ERR) begin
				state_ff <= ST_IDLE;
			end
		end
	end

	// apb slave, one wait state
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			if (psel & penable & ~pready) begin
				case (paddr)
				`NV_A_CTRLA: begin
					prdata[`NV_F_RWS] <= rws_ff;
					prdata[`NV_F_WM] <= write_mode_select_ff;
					prdata[`NV_F_FRB] <= frb_ff;
				end
				`NV_A_CTRLB: prdata <= 32'h00000000;
				`NV_A_STATUS: begin
					prdata[`NV_B_READY] <= ready_ff;
					prdata[`NV_B_ORDER] <= order_ff;
					prdata[`NV_B_ALOCK] <= alock_ff;
					prdata[`NV_F_BOOT] <= boot_ff;
				end
				`NV_A_INTFLAG: begin
					prdata[`NV_B_DONE] <= done_ff;
					prdata[`NV_B_ADDRE] <= addre_ff;
					prdata[`NV_B_PROGE] <= proge_ff;
				end
				`NV_A_ADDR: prdata[AW-1:0] <= addr_ff;
				`NV_A_REGION_UNLOCK_STATUS: prdata <= unlock_ff;
				`NV_A_SEESTAT: prdata[`NV_F_BLK] <= eeblk_ff;
				`NV_A_PARAM: prdata[15:0] <= PAGES;
				default: pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ---- test/nvmcac_chk.sv ----
// nvmcac_chk.sv: port assertions for the flash access block
// assumes binding into nvmcac_top, single clock pclk
`timescale 1ns/1ns
`default_nettype none
module nvmcac_chk #(
	parameter FLASH_KB = 1024,
	parameter AW       = 24
) (
	input wire logic            pclk,                  // clock
	input wire logic            presetn,               // reset
	input wire logic            psel,                  // apb
	input wire logic            penable,               // apb
	input wire logic            pready,                // apb
	input wire logic            pslverr,               // apb
	input wire logic [5:0]      ahb_htrans,            // ahb
	input wire logic [3*AW-1:0] ahb_haddr,             // ahb
	input wire logic [2:0]      ahb_hreadyout,         // ahb
	input wire logic [2:0]      ahb_hresp,             // ahb
	input wire logic            flash_rd_req,          // array
	input wire logic [AW-1:0]   flash_rd_addr,         // array
	input wire logic            flash_cmd_req,         // array
	input wire logic [6:0]      flash_cmd_code,        // array
	input wire logic [AW-1:0]   flash_cmd_addr,        // array
	input wire logic            flash_cmd_done,        // array
	input wire logic [3:0]      cfg_boot_protect_size, // config
	input wire logic [3:0]      cfg_emulation_blocks   // config
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire [31:0] top_a   = FLASH_KB * 1024;
	wire [31:0] emu_lo  = top_a - {cfg_emulation_blocks, 14'h0000};
	wire [31:0] boot_hi = {15'h0000, 4'hF - cfg_boot_protect_size, 13'h0000};
	wire [31:0] a0      = 32'(ahb_haddr[AW-1:0]);
	wire [31:0] cmd_a   = 32'(flash_cmd_addr);
	wire [31:0] rd_a    = 32'(flash_rd_addr);
	logic       busy_ff;
	// user page sits above the main array, so only the top slice is guarded
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			busy_ff <= 1'b0;
		else if (flash_cmd_req)
			busy_ff <= 1'b1;
		else if (flash_cmd_done)
			busy_ff <= 1'b0;
	end
	sequence err_first;
		!ahb_hreadyout[0] && ahb_hresp[0];
	endsequence
	sequence err_last;
		ahb_hreadyout[0] && ahb_hresp[0];
	endsequence
	a_emu_port_err: assert property (ahb_hreadyout[0] && ahb_htrans[1] && a0 >= emu_lo && a0 < top_a
		|-> ##[1:4] err_first) else $error("emulation area access not refused");
	a_err_two_cycle: assert property ($rose(ahb_hresp[0]) |-> err_first ##1 err_last ##1 !ahb_hresp[0])
		else $error("error response not two cycles");
	a_no_emu_read: assert property (flash_rd_req |-> rd_a < emu_lo || rd_a >= top_a)
		else $error("array read inside emulation area");
	a_no_emu_cmd: assert property (flash_cmd_req |-> cmd_a < emu_lo || cmd_a >= top_a)
		else $error("command issued inside emulation area");
	a_boot_guard: assert property (flash_cmd_req && flash_cmd_code inside {7'h00, 7'h01, 7'h03, 7'h04}
		|-> cmd_a >= boot_hi) else $error("boot area written or erased");
	a_one_at_time: assert property (flash_cmd_req |-> !busy_ff)
		else $error("command started while busy");
	a_cmd_pulse: assert property (flash_cmd_req |=> !flash_cmd_req)
		else $error("command start longer than one cycle");
	a_apb_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer timing wrong");
	a_slverr_ready: assert property (pslverr |-> pready)
		else $error("slave error without ready");
endmodule
bind nvmcac_top nvmcac_chk #(.FLASH_KB(FLASH_KB), .AW(AW)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .ahb_htrans(ahb_htrans), .ahb_haddr(ahb_haddr),
	.ahb_hreadyout(ahb_hreadyout), .ahb_hresp(ahb_hresp), .flash_rd_req(flash_rd_req),
	.flash_rd_addr(flash_rd_addr), .flash_cmd_req(flash_cmd_req), .flash_cmd_code(flash_cmd_code),
	.flash_cmd_addr(flash_cmd_addr), .flash_cmd_done(flash_cmd_done),
	.cfg_boot_protect_size(cfg_boot_protect_size), .cfg_emulation_blocks(cfg_emulation_blocks)
);
`default_nettype wire

// ---- test/nvmcac_flash_model.sv ----
// nvmcac_flash_model.sv: flash array stand-in, reads and timed operations
// assumes requests on pclk; busy_len of 0 never finishes
`timescale 1ns/1ns
`default_nettype none
module nvmcac_flash_model (
	input  wire logic        pclk,           // clock
	input  wire logic        presetn,        // reset
	input  wire logic [23:0] flash_rd_addr,  // held read address
	output var  logic [31:0] flash_rdata,    // read data
	input  wire logic        flash_cmd_req,  // operation start
	input  wire logic [7:0]  busy_len,       // operation length
	output var  logic        flash_cmd_done  // end pulse
);
	logic [7:0] cnt_ff;
	// low bits only, so bank-relative and absolute addresses read alike
	assign flash_rdata = 32'hA5000000 | 32'(flash_rd_addr[18:0]);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 8'h00;
			flash_cmd_done <= 1'b0;
		end else begin
			flash_cmd_done <= (cnt_ff == 8'h01);
			if (flash_cmd_req)
				cnt_ff <= busy_len;
			else if (cnt_ff != 8'h00)
				cnt_ff <= cnt_ff - 8'h01;
		end
	end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// tb.sv: self-checking bench for the flash access block
// assumes the array model answers reads and operations on pclk
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, busy_len;
	logic [31:0] pwdata, prdata, ahb_hrdata, flash_rdata, apb_q;
	logic [5:0]  ahb_htrans;
	logic [71:0] ahb_haddr;
	logic [2:0]  ahb_hwrite, ahb_hreadyout, ahb_hresp;
	logic [8:0]  ahb_hburst;
	logic [95:0] ahb_hwdata;
	logic        flash_rd_req, flash_rd_bank, flash_cmd_req, flash_cmd_done, apb_err, rd_bank;
	logic        flash_cmd_bank, pb_wr, order_sel;
	logic [23:0] flash_rd_addr, flash_cmd_addr, pb_addr;
	logic [31:0] pb_wdata;
	int          pb_n = 0;
	logic [6:0]  flash_cmd_code;
	logic [31:0] rd_d [2];
	logic        rd_e [2];
	int          rd_n [2];
	int          err_count = 0;
	int          num_checks = 0;
	nvmcac_top #(.FLASH_KB(1024)) uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
		.prdata, .pslverr, .ahb_htrans, .ahb_haddr, .ahb_hwrite, .ahb_hburst, .ahb_hwdata, .ahb_hreadyout,
		.ahb_hresp, .ahb_hrdata, .flash_rd_req, .flash_rd_bank, .flash_rd_addr, .flash_rdata, .pb_wr,
		.pb_addr, .pb_wdata, .flash_cmd_req, .flash_cmd_code, .flash_cmd_addr, .flash_cmd_bank,
		.flash_cmd_done, .cfg_region_unlock(32'hFFFFFFFF), .cfg_boot_protect_size(4'hE),
		.cfg_emulation_blocks(4'h1), .cfg_bank_order_select(order_sel));
	nvmcac_flash_model u_mem (.pclk, .presetn, .flash_rd_addr, .flash_rdata, .flash_cmd_req, .busy_len,
		.flash_cmd_done);
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk)
		if (flash_rd_req === 1'b1)
			rd_bank <= flash_rd_bank;
	always @(posedge pclk)
		if (pb_wr === 1'b1)
			pb_n <= pb_n + 1;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		apb_q = prdata;
		apb_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk(apb_q, e);
	endtask
	task wait_ready;
		do
			apb(8'h08, 1'b0, 32'h0);
		while (apb_q[0] !== 1'b1);
		chk({31'h0, apb_q[0]}, 32'h1);
	endtask
	task cmd(input logic [6:0] c);
		apb(8'h04, 1'b1, {16'h0, 8'hA5, 1'b0, c});
	endtask
	// both ports launch on one edge; results gathered as each completes
	task ahb_go(input logic [1:0] m, input logic [23:0] a0, input logic [23:0] a1);
		logic [1:0] pend;
		@(posedge pclk);
		ahb_htrans <= {2'b00, m[1], 1'b0, m[0], 1'b0};
		ahb_haddr <= {24'h0, a1, a0};
		@(posedge pclk);
		ahb_htrans <= 6'h00;
		pend = m;
		for (int k = 1; pend != 2'b00; k++) begin
			@(posedge pclk);
			for (int p = 0; p < 2; p++)
				if (pend[p] && ahb_hreadyout[p] === 1'b1) begin
					pend[p] = 1'b0;
					rd_d[p] = ahb_hrdata;
					rd_e[p] = ahb_hresp[p];
					rd_n[p] = k;
				end
		end
	endtask
	task t_reset_view;
		rd_chk(8'h08, 32'h00000E03);
		rd_chk(8'h0C, 32'h0);
		rd_chk(8'h14, 32'hFFFFFFFF);
		rd_chk(8'h1C, 32'h00000800);
		apb(8'h20, 1'b0, 32'h0);
		chk({31'h0, apb_err}, 32'h1);
	endtask
	task t_refusals;
		logic [23:0] ad [5] = '{24'h000000, 24'h001FFC, 24'h040000, 24'h0FC000, 24'h040000};
		logic [6:0]  cd [5] = '{7'h01, 7'h01, 7'h00, 7'h01, 7'h7F};
		logic [31:0] fl [5] = '{32'h4, 32'h4, 32'h4, 32'h3, 32'h5};
		for (int i = 0; i < 5; i++) begin
			apb(8'h10, 1'b1, {8'h00, ad[i]});
			cmd(cd[i]);
			rd_chk(8'h0C, fl[i]);
			apb(8'h0C, 1'b1, 32'h7);
		end
	endtask
	task t_busy;
		apb(8'h10, 1'b1, 32'h00040000);
		cmd(7'h01);
		rd_chk(8'h08, 32'h00000E02);
		cmd(7'h01);
		apb(8'h10, 1'b1, 32'h00050000);
		rd_chk(8'h0C, 32'h6);
		wait_ready;
		rd_chk(8'h0C, 32'h7);
		rd_chk(8'h10, 32'h00040000);
		apb(8'h0C, 1'b1, 32'h0);
		rd_chk(8'h0C, 32'h7);
		apb(8'h0C, 1'b1, 32'h5);
		cmd(7'h01);
		rd_chk(8'h0C, 32'h6);
		apb(8'h0C, 1'b1, 32'h7);
		rd_chk(8'h0C, 32'h0);
	endtask
	task t_lock;
		apb(8'h10, 1'b1, 32'h00048000);
		cmd(7'h11);
		rd_chk(8'h14, 32'hFFFFFDFF);
		cmd(7'h01);
		rd_chk(8'h0C, 32'h5);
		cmd(7'h12);
		rd_chk(8'h14, 32'hFFFFFFFF);
		apb(8'h0C, 1'b1, 32'h7);
	endtask
	task t_read;
		apb(8'h00, 1'b1, 32'h2);
		ahb_go(2'b01, 24'h040000, 24'h0);
		chk(rd_d[0], 32'hA5040000);
		chk(rd_n[0], 5);
		chk(rd_bank, 1'b0);
		ahb_go(2'b11, 24'h0FC000, 24'h0FBFFC);
		chk(rd_e[0], 1'b1);
		chk(rd_d[1], 32'hA507BFFC);
		chk(rd_bank, 1'b1);
		apb(8'h00, 1'b1, 32'h0);
		ahb_go(2'b11, 24'h040010, 24'h040020);
		chk(rd_n[0], 3);
		chk(rd_d[1], 32'hA5040020);
		chk(rd_n[1] > rd_n[0], 1'b1);
	endtask
	// double-word auto mode: first word locks the address, second starts the write
	task t_write;
		apb(8'h00, 1'b1, 32'h10);
		ahb_hwrite <= 3'b001;
		ahb_hwdata <= {64'h0, 32'h1234ABCD};
		ahb_go(2'b01, 24'h040008, 24'h0);
		chk(rd_n[0], 2);
		rd_chk(8'h08, 32'h00000E07);
		apb(8'h10, 1'b1, 32'h00050000);
		rd_chk(8'h0C, 32'h2);
		apb(8'h0C, 1'b1, 32'h7);
		ahb_go(2'b01, 24'h04000C, 24'h0);
		rd_chk(8'h10, 32'h0004000C);
		rd_chk(8'h08, 32'h00000E02);
		chk(flash_cmd_code, 32'h4);
		chk(flash_cmd_addr, 32'h0004000C);
		chk(flash_cmd_bank, 32'h0);
		chk(pb_addr, 32'h0004000C);
		chk(pb_wdata, 32'h1234ABCD);
		chk(pb_n, 2);
		wait_ready;
		rd_chk(8'h0C, 32'h1);
		apb(8'h0C, 1'b1, 32'h1);
		ahb_hwrite <= 3'b000;
		apb(8'h00, 1'b1, 32'h0);
	endtask
	// second reset with the other bank order
	task t_swap;
		presetn <= 1'b0;
		order_sel <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rd_chk(8'h08, 32'h00000E01);
		ahb_go(2'b01, 24'h040000, 24'h0);
		chk(rd_bank, 1'b1);
		chk(rd_d[0], 32'hA5040000);
	endtask
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{ahb_htrans, ahb_haddr, ahb_hwrite, ahb_hburst, ahb_hwdata} = '0;
		busy_len = 8'd60;
		order_sel = 1'b1;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		t_reset_view;
		t_refusals;
		t_busy;
		t_lock;
		t_read;
		t_write;
		t_swap;
		tally_and_finish;
	end
	initial begin
		#40000;
		err_count++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
